// ---- dv/pci_target_image_decode_tb.sv ----
// self-checking bench for one inbound window
// assumes the eeprom model drives loader and config base inputs
`timescale 1ns/1ps
module pci_target_image_decode_tb;
	logic clk_sys, nrst, pci_rst_n, host_bus_hold_strap, eeprom_present_strap;
	logic ee_load, ee_space, ee_cfg_base_on, config_base_space, cfg_bit;
	logic global_byte_order, reg_wr, reg_rd, pci_addr_valid, pci_io, pci_write;
	logic dec_valid, dec_hit, lb_byte_order, lb_post, lb_prefetch, lb_burst;
	logic cfg_base_enabled;
	logic [1:0] lb_width;
	logic [3:0] ee_size_code, lb_txn_code;
	logic [11:0] reg_addr;
	logic [15:0] config_base_reg0;
	logic [31:0] reg_wdata, reg_rdata, pci_addr, lb_addr, c_ctl, c_add;
	int n_errors, comparisons, cycles;
	ptid_target_image i_dut (.clk_sys, .nrst, .pci_rst_n, .host_bus_hold_strap,
		.eeprom_present_strap, .ee_load, .ee_size_code, .ee_space,
		.ee_cfg_base_on, .config_base_reg0, .config_base_space,
		.global_byte_order, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.pci_addr_valid, .pci_addr, .pci_io, .pci_write, .dec_valid, .dec_hit,
		.lb_addr, .lb_width, .lb_txn_code, .lb_byte_order, .lb_post,
		.lb_prefetch, .lb_burst, .cfg_base_enabled);
	ptid_eeprom_model i_ee (.clk_sys, .pci_rst_n, .cfg_bit, .ee_load,
		.ee_size_code, .ee_space, .ee_cfg_base_on, .config_base_reg0,
		.config_base_space);
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", reg_rdata, exp);
	endtask
	// expectations come from the shadow copies c_ctl and c_add
	task automatic dec(input logic [31:0] a, input logic io, input logic w);
		logic [15:0] m;
		logic h;
		m = 16'hffff << c_ctl[27:24];
		h = c_ctl[31] & (((a[31:16] ^ c_add[31:16]) & m) == 16'h0);
		h = h & (io == c_ctl[6]);
		@(posedge clk_sys);
		pci_addr_valid <= 1'b1;
		pci_addr <= a;
		pci_io <= io;
		pci_write <= w;
		@(posedge clk_sys);
		pci_addr_valid <= 1'b0;
		#1;
		check("dec_valid", dec_valid, 1'b1);
		check("dec_hit", dec_hit, h);
		check("lb_addr", lb_addr, {(c_add[15:0] & m) | (a[31:16] & ~m),
			a[15:0]});
		check("lb_post", lb_post, h & w & ~io & c_ctl[7]);
		check("lb_prefetch", lb_prefetch, h & ~w & c_ctl[23]);
		check("lb_burst", lb_burst, h & w & c_ctl[22]);
		check("lb_byte_order", lb_byte_order,
			global_byte_order ^ c_ctl[19]);
		check("lb_width", lb_width, c_ctl[11:10]);
		check("lb_txn_code", lb_txn_code, c_ctl[15:12]);
	endtask
	// straps settle after nrst lets their synchronisers run
	task automatic rst(input logic h, input logic p, input logic pci);
		int i;
		@(posedge clk_sys);
		host_bus_hold_strap <= h;
		eeprom_present_strap <= p;
		nrst <= 1'b0;
		pci_rst_n <= !pci;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		pci_rst_n <= 1'b1;
		for (i = 0; i < 20 && ee_load !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		{nrst, pci_rst_n, reg_wr, reg_rd, pci_addr_valid, pci_io} = 6'h00;
		{pci_write, global_byte_order, host_bus_hold_strap} = 3'h0;
		{eeprom_present_strap, cfg_bit} = 2'h1;
		{reg_addr, reg_wdata, pci_addr} = 76'h0;
		rst(1'b0, 1'b0, 1'b1);
		check("cfg_base_enabled", cfg_base_enabled, 1'b0);
		rd(12'h100, 32'h00000000);
		rd(12'h104, 32'h00000000);
		rd(12'h108, 32'h00000000);
		wr(12'h100, 32'hffffffff);
		rd(12'h100, 32'h8fc8fcc0);
		wr(12'h104, 32'h12341234);
		rd(12'h104, 32'h12341234);
		c_add = 32'h1234a5a5;
		wr(12'h104, c_add);
		$display("test reset_rw done");
		for (int k = 0; k < 16; k++) begin
			c_ctl = {4'h8, k[3:0], k[1], k[2], 2'h0, k[0], 3'h0, k[3:0],
				k[1:0], 2'h0, k[2], 7'h00};
			global_byte_order <= k[3];
			wr(12'h100, c_ctl);
			dec({c_add[31:16] ^ (16'h1 << k), 16'h5678}, 1'b0, k[0]);
			dec({c_add[31:16] ^ ((16'h1 << k) >> 1), 16'h9abc}, 1'b0,
				k[1]);
		end
		dec({c_add[31:16], 16'h0}, 1'b1, 1'b1);
		c_ctl[31] = 1'b0;
		wr(12'h100, c_ctl);
		dec({c_add[31:16], 16'h0}, 1'b0, 1'b1);
		$display("test decode done");
		rst(1'b0, 1'b0, 1'b0);
		rd(12'h100, 32'h0f000000);
		rd(12'h104, 32'h12340000);
		$display("test global_reset done");
		rst(1'b0, 1'b1, 1'b1);
		check("cfg_base_enabled", cfg_base_enabled, 1'b1);
		rd(12'h100, 32'h03000040);
		rd(12'h104, 32'hc0000000);
		wr(12'h100, 32'h8fc00080);
		rd(12'h100, 32'h83c000c0);
		wr(12'h104, 32'h55551111);
		rd(12'h104, 32'hc0001111);
		c_ctl = 32'h83c000c0;
		c_add = 32'hc0001111;
		dec(32'hc0023456, 1'b1, 1'b1);
		dec(32'hc0023456, 1'b0, 1'b0);
		dec(32'hc0043456, 1'b1, 1'b0);
		dec(32'hc8000000, 1'b1, 1'b0);
		$display("test eeprom_load done");
		cfg_bit <= 1'b0;
		rst(1'b1, 1'b1, 1'b1);
		check("cfg_base_enabled", cfg_base_enabled, 1'b1);
		wr(12'h100, 32'h05000000);
		rd(12'h100, 32'h05000000);
		rd(12'h104, 32'hc0000000);
		$display("test hold_strap done");
		print_verdict();
	end
endmodule

// ---- dv/ptid_eeprom_model.sv ----
// stand-in for the serial eeprom loader and the pci config base register
// assumes one clk_sys domain; loads once after each pci reset release
`timescale 1ns/1ps
module ptid_eeprom_model #(
	parameter logic [3:0] SIZE = 4'h3,
	parameter logic SPACE = 1'b1,
	parameter logic [15:0] BAR = 16'hc000
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic pci_rst_n,
	// eeprom image option
	input wire logic cfg_bit,
	// loader side
	output logic ee_load,
	output logic [3:0] ee_size_code,
	output logic ee_space,
	output logic ee_cfg_base_on,
	// config base register
	output logic [15:0] config_base_reg0,
	output logic config_base_space
);
	logic [3:0] cnt;
	// data lines carry junk outside the load pulse, as a real loader may
	assign ee_size_code = ee_load ? SIZE : ~SIZE;
	assign ee_space = ee_load ? SPACE : ~SPACE;
	assign ee_cfg_base_on = cfg_bit;
	assign config_base_reg0 = BAR;
	assign config_base_space = SPACE;
	always_ff @(posedge clk_sys or negedge pci_rst_n) begin
		if (!pci_rst_n) begin
			cnt <= 4'h0;
			ee_load <= 1'b0;
		end else begin
			cnt <= (cnt == 4'hf) ? cnt : cnt + 4'h1;
			ee_load <= (cnt == 4'h7);
		end
	end
endmodule

// ---- logic/ptid_pkg.sv ----
// constants for one inbound address window of the bus bridge
// assumes a single clk_sys domain; straps arrive from pins
// Operation
// - claim only while enabled, hit and space match
// - size code picks window of 64K times two^code
// - compare selected upper lines against base field
// - translated lines replace compared ones, low pass
// - port width and user code go out
// - flip bit inverts global byte order
// - space bit: 0 memory, 1 I/O
// - post only memory writes with posting allowed
// - eeprom load sets size/space, read-only
// - without eeprom size/space zero and writable
// - hold strap high keeps size/space writable
// - config base enabled by eeprom bit or strap
// - enabled config base makes base read-only mirror
// - otherwise base field plain read/write
// - writable base reads zero after pci reset
// - translate field always plain read/write
package ptid_pkg;
	localparam logic [11:0] ptid_off_ctl = 12'h100;
	localparam logic [11:0] ptid_off_add = 12'h104;
	localparam int ptid_bit_en = 31;
	localparam int ptid_pos_size = 24;
	localparam int ptid_bit_prefetch = 23;
	localparam int ptid_bit_burst = 22;
	localparam int ptid_bit_flip = 19;
	localparam int ptid_pos_code = 12;
	localparam int ptid_pos_width = 10;
	localparam int ptid_bit_post = 7;
	localparam int ptid_bit_space = 6;
	localparam int ptid_pos_base = 16;
	localparam int ptid_pos_xlat = 0;
	localparam logic [3:0] ptid_rst_size = 4'h0;
	localparam logic ptid_rst_space = 1'b0;
	localparam logic [15:0] ptid_rst_base = 16'h0000;
	localparam logic [15:0] ptid_rst_xlat = 16'h0000;
	localparam logic [3:0] ptid_rst_code = 4'h0;
	localparam logic [1:0] ptid_rst_width = 2'h0;
	localparam logic [1:0] ptid_width_32 = 2'h0;
	localparam logic [1:0] ptid_width_8 = 2'h1;
	localparam logic [1:0] ptid_width_16 = 2'h2;
endpackage

// ---- logic/ptid_target_image.sv ----
// one inbound window: registers, strap capture and address decode
// assumes register strobes and eeprom/config inputs come from clk_sys logic
`timescale 1ns/1ps
module ptid_target_image (
	// clock and resets
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic pci_rst_n,
	// power-up pins
	input wire logic host_bus_hold_strap,
	input wire logic eeprom_present_strap,
	// eeprom loader
	input wire logic ee_load,
	input wire logic [3:0] ee_size_code,
	input wire logic ee_space,
	input wire logic ee_cfg_base_on,
	// pci configuration base register
	input wire logic [15:0] config_base_reg0,
	input wire logic config_base_space,
	// global setting
	input wire logic global_byte_order,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	// pci address phase
	input wire logic pci_addr_valid,
	input wire logic [31:0] pci_addr,
	input wire logic pci_io,
	input wire logic pci_write,
	// local bus request
	output logic dec_valid,
	output logic dec_hit,
	output logic [31:0] lb_addr,
	output logic [1:0] lb_width,
	output logic [3:0] lb_txn_code,
	output logic lb_byte_order,
	output logic lb_post,
	output logic lb_prefetch,
	output logic lb_burst,
	// status
	output logic cfg_base_enabled
);
	logic hold_s1, hold_s2, pres_s1, pres_s2;
	logic hold_latched, pres_latched;
	logic enable, prefetch_allow, burst_write_allow, byte_order_flip;
	logic [3:0] user_txn_code;
	logic [1:0] target_port_width;
	logic posting_allow;
	logic [15:0] window_translate;
	logic [3:0] window_size_code;
	logic space_reg;
	logic ee_loaded;
	logic [15:0] base_reg;

	wire logic sel_ctl, sel_add, wr_ctl, wr_add;
	wire logic size_writable;
	wire logic space_select;
	wire logic [15:0] base_eff;
	wire logic in_window, claim;
	wire logic [31:0] xlat_addr;
	wire logic [31:0] ctl_word, add_word;

	// pins pass two flops before anything looks at them
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			hold_s1 <= 1'b0;
			hold_s2 <= 1'b0;
			pres_s1 <= 1'b0;
			pres_s2 <= 1'b0;
		end else begin
			hold_s1 <= host_bus_hold_strap;
			hold_s2 <= hold_s1;
			pres_s1 <= eeprom_present_strap;
			pres_s2 <= pres_s1;
		end
	end

	// straps follow the pin while pci reset is low, freeze at release
	always_ff @(posedge clk_sys) begin
		if (!pci_rst_n) begin
			hold_latched <= hold_s2;
			pres_latched <= pres_s2;
		end
	end

	assign sel_ctl = reg_addr == ptid_pkg::ptid_off_ctl;
	assign sel_add = reg_addr == ptid_pkg::ptid_off_add;
	assign wr_ctl = reg_wr && sel_ctl;
	assign wr_add = reg_wr && sel_add;

	// eeprom bit only counts with an eeprom fitted
	assign cfg_base_enabled = (ee_cfg_base_on && pres_latched)
		|| hold_latched;
	assign size_writable = !ee_loaded || hold_latched;
	// a loaded space bit tracks the config register unless the hold strap is latched
	assign space_select = (ee_loaded && !hold_latched) ?
		config_base_space : space_reg;
	assign base_eff = cfg_base_enabled ? config_base_reg0 : base_reg;

	// attributes on the global reset
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			enable <= 1'b0;
			prefetch_allow <= 1'b0;
			burst_write_allow <= 1'b0;
			byte_order_flip <= 1'b0;
			user_txn_code <= ptid_pkg::ptid_rst_code;
			target_port_width <= ptid_pkg::ptid_rst_width;
			posting_allow <= 1'b0;
		end else if (wr_ctl) begin
			enable <= reg_wdata[ptid_pkg::ptid_bit_en];
			prefetch_allow <= reg_wdata[ptid_pkg::ptid_bit_prefetch];
			burst_write_allow <= reg_wdata[ptid_pkg::ptid_bit_burst];
			byte_order_flip <= reg_wdata[ptid_pkg::ptid_bit_flip];
			user_txn_code <= reg_wdata[ptid_pkg::ptid_pos_code +: 4];
			target_port_width <= reg_wdata[ptid_pkg::ptid_pos_width +: 2];
			posting_allow <= reg_wdata[ptid_pkg::ptid_bit_post];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			window_translate <= ptid_pkg::ptid_rst_xlat;
		else if (wr_add)
			window_translate <= reg_wdata[ptid_pkg::ptid_pos_xlat +: 16];
	end

	// size, space and base live on the pci reset
	always_ff @(posedge clk_sys or negedge pci_rst_n) begin
		if (!pci_rst_n) begin
			window_size_code <= ptid_pkg::ptid_rst_size;
			space_reg <= ptid_pkg::ptid_rst_space;
			ee_loaded <= 1'b0;
		end else if (ee_load && pres_latched) begin
			window_size_code <= ee_size_code;
			space_reg <= ee_space;
			ee_loaded <= 1'b1;
		end else if (wr_ctl && size_writable) begin
			window_size_code <= reg_wdata[ptid_pkg::ptid_pos_size +: 4];
			space_reg <= reg_wdata[ptid_pkg::ptid_bit_space];
		end
	end

	always_ff @(posedge clk_sys or negedge pci_rst_n) begin
		if (!pci_rst_n)
			base_reg <= ptid_pkg::ptid_rst_base;
		else if (wr_add && !cfg_base_enabled)
			base_reg <= reg_wdata[ptid_pkg::ptid_pos_base +: 16];
	end

	// reserved bits read zero
	assign ctl_word = ({31'h0, enable} << ptid_pkg::ptid_bit_en)
		| ({28'h0, window_size_code} << ptid_pkg::ptid_pos_size)
		| ({31'h0, prefetch_allow} << ptid_pkg::ptid_bit_prefetch)
		| ({31'h0, burst_write_allow} << ptid_pkg::ptid_bit_burst)
		| ({31'h0, byte_order_flip} << ptid_pkg::ptid_bit_flip)
		| ({28'h0, user_txn_code} << ptid_pkg::ptid_pos_code)
		| ({30'h0, target_port_width} << ptid_pkg::ptid_pos_width)
		| ({31'h0, posting_allow} << ptid_pkg::ptid_bit_post)
		| ({31'h0, space_select} << ptid_pkg::ptid_bit_space);
	assign add_word = {base_eff, window_translate};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			reg_rdata <= 32'h0;
		else if (reg_rd)
			reg_rdata <= sel_ctl ? ctl_word : (sel_add ? add_word : 32'h0);
	end

	ptid_window_match #(.HI_W(16)) u_match (
		.addr(pci_addr),
		.size_code(window_size_code),
		.base(base_eff),
		.xlat(window_translate),
		.in_window(in_window),
		.out_addr(xlat_addr)
	);

	// space bit picks memory or i/o cycles
	assign claim = enable && in_window && (pci_io == space_select);

	// outputs other than dec_valid held until the next address phase
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dec_valid <= 1'b0;
			dec_hit <= 1'b0;
			lb_addr <= 32'h0;
			lb_width <= ptid_pkg::ptid_width_32;
			lb_txn_code <= 4'h0;
			lb_byte_order <= 1'b0;
			lb_post <= 1'b0;
			lb_prefetch <= 1'b0;
			lb_burst <= 1'b0;
		end else begin
			dec_valid <= pci_addr_valid;
			if (pci_addr_valid) begin
				dec_hit <= claim;
				lb_addr <= xlat_addr;
				lb_width <= target_port_width;
				lb_txn_code <= user_txn_code;
				lb_byte_order <= global_byte_order ^ byte_order_flip;
				// i/o writes are never posted
				lb_post <= claim && pci_write && !pci_io && posting_allow;
				lb_prefetch <= claim && !pci_write && prefetch_allow;
				lb_burst <= claim && pci_write && burst_write_allow;
			end
		end
	end

	// second model of the window, kept apart from the match module
	wire logic [15:0] chk_mask;
	wire logic chk_match;
	wire logic [15:0] chk_upper;
	assign chk_mask = 16'hffff << window_size_code;
	assign chk_match = ((pci_addr[31:16] ^ base_eff) & chk_mask) == 16'h0;
	assign chk_upper = (window_translate & chk_mask)
		| (pci_addr[31:16] & ~chk_mask);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst || !pci_rst_n);

	a_hit_needs_enable: assert property (pci_addr_valid && !enable
		|=> dec_valid && !dec_hit) else $error("hit while disabled");
	a_space_mismatch_miss: assert property (pci_addr_valid
		&& (pci_io != space_select) |=> !dec_hit)
		else $error("hit in wrong space");
	a_low_lines_pass: assert property (dec_valid
		|-> lb_addr[15:0] == $past(pci_addr[15:0]))
		else $error("low lines altered");
	a_full_size_hit: assert property (pci_addr_valid && enable
		&& window_size_code == 4'hf && (pci_io == space_select)
		&& pci_addr[31] == base_eff[15] |=> dec_hit)
		else $error("top-line window missed");
	a_io_never_posted: assert property (dec_valid && $past(pci_io)
		|-> !lb_post) else $error("i/o write posted");
	a_order_flip: assert property (dec_valid |-> lb_byte_order
		== ($past(global_byte_order) ^ $past(byte_order_flip)))
		else $error("byte order wrong");
	a_base_mirror_read: assert property (reg_rd && sel_add
		&& cfg_base_enabled
		|=> reg_rdata[31:16] == $past(config_base_reg0))
		else $error("base not mirrored");
	a_size_locked: assert property (wr_ctl && !size_writable
		&& !ee_load |=> $stable(window_size_code))
		else $error("locked size written");
	a_translate_write: assert property (wr_add ##1 !reg_wr
		##1 reg_rd && sel_add
		|=> reg_rdata[15:0] == $past(reg_wdata[15:0], 3))
		else $error("translate not stored");
	a_prefetch_gate: assert property (dec_valid && lb_prefetch
		|-> dec_hit && $past(prefetch_allow))
		else $error("prefetch not allowed");
	a_window_miss: assert property (pci_addr_valid && !chk_match
		|=> dec_valid && !dec_hit) else $error("miss claimed");
	a_window_hit: assert property (pci_addr_valid && enable
		&& chk_match && (pci_io == space_select) |=> dec_hit)
		else $error("window hit not claimed");
	a_upper_replaced: assert property (dec_valid
		|-> lb_addr[31:16] == $past(chk_upper))
		else $error("upper lines not translated");
	a_width_copy: assert property (dec_valid
		|-> lb_width == $past(target_port_width))
		else $error("port width not passed");
	a_code_copy: assert property (dec_valid
		|-> lb_txn_code == $past(user_txn_code))
		else $error("transaction code not passed");
	a_post_gate: assert property (dec_valid && lb_post
		|-> dec_hit && $past(posting_allow)
		&& $past(pci_write)) else $error("post not allowed");
	a_post_memory: assert property (pci_addr_valid && claim
		&& pci_write && !pci_io && posting_allow |=> lb_post)
		else $error("memory write not posted");
	a_burst_gate: assert property (dec_valid && lb_burst
		|-> dec_hit && $past(burst_write_allow)
		&& $past(pci_write)) else $error("burst not allowed");
	a_burst_allowed: assert property (pci_addr_valid && claim
		&& pci_write && burst_write_allow |=> lb_burst)
		else $error("burst write not granted");
	a_base_locked: assert property (wr_add && cfg_base_enabled
		|=> $stable(base_reg)) else $error("locked base written");
	a_base_written: assert property (wr_add && !cfg_base_enabled
		|=> base_reg == $past(reg_wdata[31:16]))
		else $error("base not written");
	a_translate_stored: assert property (wr_add
		|=> window_translate == $past(reg_wdata[15:0]))
		else $error("translate not written");
	a_global_clear: assert property ($rose(nrst)
		|-> !enable && !posting_allow
		&& window_translate == ptid_pkg::ptid_rst_xlat)
		else $error("attributes not cleared");
	a_pci_reset_init: assert property ($rose(pci_rst_n)
		|-> window_size_code == ptid_pkg::ptid_rst_size
		&& base_reg == ptid_pkg::ptid_rst_base)
		else $error("pci reset values wrong");
	a_load_takes: assert property (ee_load && pres_latched
		|=> window_size_code == $past(ee_size_code) && ee_loaded)
		else $error("eeprom values not loaded");
	a_size_written: assert property (wr_ctl && size_writable
		&& !ee_load
		|=> window_size_code == $past(reg_wdata[27:24]))
		else $error("writable size not stored");

	c_hit_read: cover property (dec_valid && dec_hit && lb_prefetch);
	c_posted_write: cover property (dec_valid && lb_post);
	c_io_hit: cover property (dec_valid && dec_hit && space_select);
	c_eeprom_load: cover property (ee_load && pres_latched);
	c_burst_write: cover property (dec_valid && dec_hit && lb_burst);
endmodule

// ---- logic/ptid_window_match.sv ----
// window compare and address substitution for one image
// assumes all inputs are stable in the same cycle; purely combinational
`timescale 1ns/1ps
module ptid_window_match #(
	parameter int HI_W = 16
) (
	// address phase
	input wire logic [31:0] addr,
	// window settings
	input wire logic [3:0] size_code,
	input wire logic [HI_W-1:0] base,
	input wire logic [HI_W-1:0] xlat,
	// results
	output logic in_window,
	output logic [31:0] out_addr
);
	wire logic [HI_W-1:0] mask;
	wire logic [HI_W-1:0] upper;
	wire logic [HI_W-1:0] new_upper;

	// each code step drops one low line from the compare
	assign mask = {HI_W{1'b1}} << size_code;
	assign upper = addr[31:32-HI_W];
	assign in_window = ((upper ^ base) & mask) == '0;
	// the same mask picks the replaced lines
	assign new_upper = (xlat & mask) | (upper & ~mask);
	assign out_addr = {new_upper, addr[31-HI_W:0]};
endmodule
